// file: include/sdm_regs.svh
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH
// register byte offsets
`define SDM_CTRL_OFS 8'h00
`define SDM_ZERO_THR_OFS 8'h04
`define SDM_LOW_THR_OFS 8'h08
`define SDM_UP_THR_OFS 8'h0C
`define SDM_OVSPD_OFS 8'h10
`define SDM_RATIO_OFS 8'h14
`define SDM_HARD_REF_OFS 8'h18
`define SDM_KP_OFS 8'h1C
`define SDM_ILIM_OFS 8'h20
`define SDM_FINAL_OFS 8'h24
`define SDM_ERR_OFS 8'h28
`define SDM_TORQUE_OFS 8'h2C
`define SDM_SLAVE_OFS 8'h30
`define SDM_STATUS_OFS 8'h34
// control field positions
`define SDM_CTRL_CLOSED 0
`define SDM_CTRL_SLAVE 1
`define SDM_CTRL_ENABLE 2
`define SDM_CTRL_HARDREF 3
`define SDM_CTRL_ABSWIN 4
`define SDM_CTRL_FD 5
`define SDM_CTRL_SINE_COSINE_ENCODER 6
`define SDM_CTRL_W 7
// status field positions
`define SDM_ST_ZERO 0
`define SDM_ST_AT 1
`define SDM_ST_ABOVE 2
`define SDM_ST_BELOW 3
`define SDM_ST_TRIP 4
`define SDM_ST_RES 5
// reset values (open loop: 0.1 Hz units, closed loop: rpm)
`define SDM_CTRL_RST 7'h00
`define SDM_ZERO_OL_RST 16'h000A
`define SDM_ZERO_CL_RST 16'h0005
`define SDM_BAND_OL_RST 16'h000A
`define SDM_BAND_CL_RST 16'h0005
`define SDM_OVSPD_RST 16'h2710
`define SDM_RATIO_RST 16'h0100
`define SDM_KP_RST 16'h00C8
`define SDM_ILIM_RST 16'h00C8
// value limits
`define SDM_SPEED_MAX 16'sh7530
`define SDM_FREQ_MAX 16'sh2710
`define SDM_RATIO_SHIFT 8
`define SDM_KP_SHIFT 4
`endif

// file: include/sdm_pkg.sv
package sdm_pkg;
   // values coming from the drive's own ramp, encoder and feedback logic
   typedef struct packed {
      logic signed [15:0] ramp_out;
      logic signed [15:0] pre_ramp_ref;
      logic signed [15:0] motor_freq;
      logic signed [15:0] enc_fb;
      logic signed [15:0] res_fb;
      logic signed [15:0] sine_cosine_encoder_fb;
      logic res_fitted;
      logic sine_cosine_encoder_fitted;
      logic sample_tick;
   } sdm_drv_in_s;
   // speed monitor indicators
   typedef struct packed {
      logic zero_speed;
      logic at_speed;
      logic above_band;
      logic below_band;
      logic overspeed_trip;
      logic resolver_sel;
   } sdm_ind_s;
endpackage

// file: hdl/sdm_top.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "sdm_regs.svh"
// How it works
// R1: slave frequency reads zero outside slaving mode
// R2: slaving reports fundamental output frequency
// R3: output frequency locks to encoder pulse rate
// R4: master sends quadrature or frequency-direction pulses
// R5: disabled ignores pulses; lock survives reversal
// R6: programmable fixed gear ratio master to slave
// R7: final demand is ramp plus enabled hard ref
// R8: final demand clamped thirty thousand, zero disabled
// R9: fitted resolver module becomes feedback source
// R10: sine-cosine module feedback selectable by setting
// R11: speed error is demand minus feedback
// R12: torque demand bounded by current limit
// R13: open loop zero speed on frequency threshold
// R14: closed loop zero speed on feedback threshold
// R15: writable lower at-speed threshold with defaults
// R16: writable upper at-speed threshold with defaults
// R17: reference window band around pre-ramp reference
// R18: absolute window band between thresholds
// R19: boundaries inside; separate above, below flags
// R20: overspeed trip above programmable threshold
// R21: indicators re-evaluated every speed sample period
module sdm_top
   import sdm_pkg::*;
#(
   parameter bit CLOSED_LOOP_DEFAULT = 1'b0
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enc_a_pin,
   input wire logic enc_b_pin,
   input wire sdm_drv_in_s drv_in,
   output logic signed [15:0] slave_freq_dmd,
   output logic signed [15:0] final_demand,
   output logic signed [15:0] torque_demand,
   output sdm_ind_s ind
);

   // saturate a wide signed value into +-lim
   function automatic logic signed [15:0] sat16(input logic signed [31:0] v, input logic signed [15:0] lim);
      logic signed [31:0] l;
      l = 32'(lim);
      if (v > l)
         sat16 = lim;
      else if (v < -l)
         sat16 = -lim;
      else
         sat16 = v[15:0];
   endfunction

   // magnitude, widened so -32768 cannot wrap
   function automatic logic signed [17:0] mag18(input logic signed [15:0] v);
      mag18 = (v < 0) ? -18'(v) : 18'(v);
   endfunction

   logic [`SDM_CTRL_W-1:0] ctrl_r;
   logic [15:0] zero_thr_r, low_thr_r, up_thr_r, ovspd_r, ratio_r, kp_r, ilim_r;
   logic signed [15:0] hard_ref_r, speed_err_r, pulse_cnt_r;
   logic a_m_r, a_s_r, b_m_r, b_s_r, a_d_r, b_d_r;
   logic closed, slave_on, enabled, trip_clr;
   logic signed [15:0] fb_sel, pulse_step;
   logic signed [17:0] speed_mag, ref_mag, band_lo, band_hi;
   logic wr_en, rd_en;

   assign closed = ctrl_r[`SDM_CTRL_CLOSED];
   assign enabled = ctrl_r[`SDM_CTRL_ENABLE];
   assign slave_on = ctrl_r[`SDM_CTRL_SLAVE] && !closed;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign trip_clr = wr_en && paddr == `SDM_STATUS_OFS && pwdata[`SDM_ST_TRIP];

   // writable registers; zero and at-speed threshold defaults follow CLOSED_LOOP_DEFAULT, not the control register's loop bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `SDM_CTRL_RST;
         zero_thr_r <= CLOSED_LOOP_DEFAULT ? `SDM_ZERO_CL_RST : `SDM_ZERO_OL_RST; // R13 R14
         low_thr_r <= CLOSED_LOOP_DEFAULT ? `SDM_BAND_CL_RST : `SDM_BAND_OL_RST; // R15
         up_thr_r <= CLOSED_LOOP_DEFAULT ? `SDM_BAND_CL_RST : `SDM_BAND_OL_RST; // R16
         ovspd_r <= `SDM_OVSPD_RST;
         ratio_r <= `SDM_RATIO_RST;
         hard_ref_r <= '0;
         kp_r <= `SDM_KP_RST;
         ilim_r <= `SDM_ILIM_RST;
      end
      else if (clk_en && wr_en)
      begin
         unique case (paddr)
            `SDM_CTRL_OFS: ctrl_r <= pwdata[`SDM_CTRL_W-1:0];
            `SDM_ZERO_THR_OFS: zero_thr_r <= pwdata[15:0];
            `SDM_LOW_THR_OFS: low_thr_r <= pwdata[15:0]; // R15
            `SDM_UP_THR_OFS: up_thr_r <= pwdata[15:0]; // R16
            `SDM_OVSPD_OFS: ovspd_r <= pwdata[15:0];
            `SDM_RATIO_OFS: ratio_r <= pwdata[15:0];
            `SDM_HARD_REF_OFS: hard_ref_r <= pwdata[15:0];
            `SDM_KP_OFS: kp_r <= pwdata[15:0];
            `SDM_ILIM_OFS: ilim_r <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // read data is latched in the setup phase so the access phase never waits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready <= 1'b1;
         pslverr <= psel && !penable && (paddr > `SDM_STATUS_OFS || paddr[1:0] != 2'h0);
         if (rd_en)
         begin
            unique case (paddr)
               `SDM_CTRL_OFS: prdata <= 32'(ctrl_r);
               `SDM_ZERO_THR_OFS: prdata <= 32'(zero_thr_r);
               `SDM_LOW_THR_OFS: prdata <= 32'(low_thr_r);
               `SDM_UP_THR_OFS: prdata <= 32'(up_thr_r);
               `SDM_OVSPD_OFS: prdata <= 32'(ovspd_r);
               `SDM_RATIO_OFS: prdata <= 32'(ratio_r);
               `SDM_HARD_REF_OFS: prdata <= 32'(hard_ref_r);
               `SDM_KP_OFS: prdata <= 32'(kp_r);
               `SDM_ILIM_OFS: prdata <= 32'(ilim_r);
               `SDM_FINAL_OFS: prdata <= 32'(final_demand); // R8
               `SDM_ERR_OFS: prdata <= 32'(speed_err_r);
               `SDM_TORQUE_OFS: prdata <= 32'(torque_demand);
               `SDM_SLAVE_OFS: prdata <= 32'(slave_freq_dmd); // R1
               `SDM_STATUS_OFS: prdata <= 32'(ind);
               default: prdata <= '0;
            endcase
         end
      end
   end

   // encoder pins are asynchronous: two flops before any decoding
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_m_r <= 1'b0;
         a_s_r <= 1'b0;
         b_m_r <= 1'b0;
         b_s_r <= 1'b0;
         a_d_r <= 1'b0;
         b_d_r <= 1'b0;
      end
      else if (clk_en)
      begin
         a_m_r <= enc_a_pin;
         a_s_r <= a_m_r;
         b_m_r <= enc_b_pin;
         b_s_r <= b_m_r;
         a_d_r <= a_s_r;
         b_d_r <= b_s_r;
      end
   end

   // pulse decode: frequency-direction counts rising edges of a, b gives sign;
   // quadrature counts every edge of a, direction from the phase of b
   always_comb
   begin
      pulse_step = '0;
      if (ctrl_r[`SDM_CTRL_FD]) // R4
      begin
         if (a_s_r && !a_d_r)
            pulse_step = b_s_r ? -16'sd1 : 16'sd1;
      end
      else if (a_s_r != a_d_r)
         pulse_step = (a_s_r == b_s_r) ? -16'sd1 : 16'sd1; // R5
   end

   // pulses are counted only while slaving and enabled; the count is turned
   // into frequency once per sample, so the lock follows reversals sign-wise
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pulse_cnt_r <= '0;
      else if (clk_en)
      begin
         if (!(slave_on && enabled))
            pulse_cnt_r <= '0; // R5
         else if (drv_in.sample_tick)
            pulse_cnt_r <= pulse_step; // R3
         else
            pulse_cnt_r <= 16'(pulse_cnt_r + pulse_step);
      end
   end

   // fundamental frequency demand = pulses per sample times gear ratio
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         slave_freq_dmd <= '0;
      else if (clk_en)
      begin
         if (!(slave_on && enabled))
            slave_freq_dmd <= '0; // R1 R5
         else if (drv_in.sample_tick)
            slave_freq_dmd <= sat16((32'(pulse_cnt_r) * 32'($signed({1'b0, ratio_r})))
                                    >>> `SDM_RATIO_SHIFT, `SDM_FREQ_MAX); // R2 R3 R6
      end
   end

   // feedback source: resolver wins when fitted, else sine-cosine if chosen
   always_comb
   begin
      if (drv_in.res_fitted)
         fb_sel = drv_in.res_fb; // R9
      else if (drv_in.sine_cosine_encoder_fitted && ctrl_r[`SDM_CTRL_SINE_COSINE_ENCODER])
         fb_sel = drv_in.sine_cosine_encoder_fb; // R10
      else
         fb_sel = drv_in.enc_fb;
   end

   // speed path: demand, error and torque, refreshed each speed sample
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         final_demand <= '0;
         speed_err_r <= '0;
         torque_demand <= '0;
      end
      else if (clk_en)
      begin
         if (!enabled || !closed)
         begin
            final_demand <= '0; // R8
            speed_err_r <= '0;
            torque_demand <= '0;
         end
         else if (drv_in.sample_tick)
         begin
            final_demand <= sat16(32'(drv_in.ramp_out) + (ctrl_r[`SDM_CTRL_HARDREF] ? 32'(hard_ref_r) : 32'sd0),
                                  `SDM_SPEED_MAX); // R7 R8
            speed_err_r <= sat16(32'(final_demand) - 32'(fb_sel), `SDM_SPEED_MAX); // R11
            torque_demand <= sat16((32'(speed_err_r) * 32'($signed({1'b0, kp_r}))) >>> `SDM_KP_SHIFT,
                                   $signed(ilim_r)); // R12
         end
      end
   end

   // monitored magnitude and at-speed band edges
   always_comb
   begin
      speed_mag = closed ? mag18(fb_sel) : mag18(drv_in.motor_freq);
      ref_mag = mag18(drv_in.pre_ramp_ref);
      if (ctrl_r[`SDM_CTRL_ABSWIN])
      begin
         band_lo = 18'($signed({1'b0, low_thr_r})); // R18
         band_hi = 18'($signed({1'b0, up_thr_r}));
      end
      else
      begin
         band_lo = 18'(ref_mag - $signed({2'b00, low_thr_r})); // R17
         band_hi = 18'(ref_mag + $signed({2'b00, up_thr_r}));
      end
   end

   // indicators update on the sample tick, resolver_sel on every enabled cycle; a trip set beats its clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ind <= '0;
      else if (clk_en)
      begin
         ind.resolver_sel <= drv_in.res_fitted; // R9
         if (drv_in.sample_tick) // R21
         begin
            ind.zero_speed <= speed_mag <= $signed({2'b00, zero_thr_r}); // R13 R14
            ind.at_speed <= speed_mag >= band_lo && speed_mag <= band_hi; // R19
            ind.above_band <= speed_mag > band_hi; // R19
            ind.below_band <= speed_mag < band_lo;
         end
         if (drv_in.sample_tick && speed_mag > $signed({2'b00, ovspd_r}))
            ind.overspeed_trip <= 1'b1; // R20
         else if (trip_clr)
            ind.overspeed_trip <= 1'b0;
      end
   end

   // checks; software may clear the trip one cycle after it sets, so hold is judged with that in mind
   property p_tick(logic c);
      @(posedge pclk) disable iff (!presetn) (clk_en && drv_in.sample_tick) |=> c;
   endproperty
   sequence s_setup;
      clk_en && psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence

   slave_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (clk_en && !slave_on) |=> slave_freq_dmd == 0)
      else $error("slave frequency not zero outside slaving");
   demand_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (clk_en && !enabled) |=> final_demand == 0)
      else $error("final demand not zero while disabled");
   demand_range_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      final_demand <= `SDM_SPEED_MAX && final_demand >= -`SDM_SPEED_MAX)
      else $error("final demand out of range");
   demand_sum_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
      (clk_en && enabled && closed && drv_in.sample_tick && !ctrl_r[`SDM_CTRL_HARDREF]
       && drv_in.ramp_out <= `SDM_SPEED_MAX && drv_in.ramp_out >= -`SDM_SPEED_MAX)
      |=> final_demand == $past(drv_in.ramp_out))
      else $error("final demand differs from ramp output");
   torque_limit_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
      mag18(torque_demand) <= $signed({2'b00, ilim_r}) || $changed(ilim_r))
      else $error("torque demand beyond current limit");
   zero_speed_a: assert property ( // R13 R14
      p_tick(ind.zero_speed == ($past(speed_mag) <= $signed({2'b00, $past(zero_thr_r)}))))
      else $error("zero speed indicator wrong");
   band_flags_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
      !(ind.at_speed && (ind.above_band || ind.below_band)) && !(ind.above_band && ind.below_band))
      else $error("at-speed flags overlap");
   trip_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
      (clk_en && drv_in.sample_tick && speed_mag > $signed({2'b00, ovspd_r}))
      |=> ind.overspeed_trip ##1 (ind.overspeed_trip || $past(clk_en && trip_clr)))
      else $error("overspeed trip missed or cleared early");
   trip_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
      (clk_en && trip_clr && !(drv_in.sample_tick && speed_mag > $signed({2'b00, ovspd_r})))
      |=> !ind.overspeed_trip)
      else $error("overspeed trip not cleared");
   resolver_pick_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
      drv_in.res_fitted |-> fb_sel == drv_in.res_fb)
      else $error("resolver not selected");
   apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup ##1 (clk_en && psel && penable) |-> s_access)
      else $error("access phase not answered at once");
endmodule

// file: bench/sdm_master_model.sv
`timescale 1ns/1ps
// master drive sending quadrature or frequency-direction pulses
module sdm_master_model
(
   input wire logic pclk,
   input wire logic run,
   input wire logic fd_mode,
   input wire logic reverse,
   output logic enc_a,
   output logic enc_b
);
   logic [1:0] ph_r = 2'h0;
   logic [1:0] cnt_r = 2'h0;
   // each phase lasts 3 cycles, safely above the 2-cycle minimum of the decoder
   always @(posedge pclk)
   begin
      if (run)
         cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
      if (run && cnt_r == 2'h2)
         ph_r <= (fd_mode || !reverse) ? ph_r + 2'h1 : ph_r - 2'h1;
   end
   // gray order 00,10,11,01 for quadrature; direction level on b for F+D
   assign enc_a = fd_mode ? ph_r[0] : (ph_r[0] ^ ph_r[1]);
   assign enc_b = fd_mode ? reverse : ph_r[1];
endmodule

// file: bench/sdm_top_tb.sv
`timescale 1ns/1ps
`include "sdm_regs.svh"
module sdm_top_tb
   import sdm_pkg::*;
;
   localparam int LO = 100, UPV = 300, RF = 500, ZT = 5, OV = 1000;
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, enc_a, enc_b, run = 1'b0, fd = 1'b0, rev = 1'b0, pa = 1'b0, tr = 1'b0, rs = 1'b0;
   sdm_drv_in_s drv = '0;
   logic signed [15:0] slave_freq_dmd, final_demand, torque_demand;
   sdm_ind_s ind;
   int num_errors = 0, check_count = 0, cyc = 0, seed = 45028, exp_cnt = 0, r, h, f, e, fin;
   logic [7:0] ra [8] = '{`SDM_CTRL_OFS, `SDM_ZERO_THR_OFS, `SDM_LOW_THR_OFS, `SDM_UP_THR_OFS,
                          `SDM_OVSPD_OFS, `SDM_RATIO_OFS, `SDM_KP_OFS, `SDM_ILIM_OFS};
   logic [15:0] rv [8] = '{16'h0000, 16'h000A, 16'h000A, 16'h000A, 16'h2710, 16'h0100, 16'h00C8, 16'h00C8};
   int sp [10] = '{5, -6, 100, 300, 301, -300, 399, 400, 800, 801};

   sdm_top #(.CLOSED_LOOP_DEFAULT(1'b0)) u_sdm_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enc_a_pin(enc_a), .enc_b_pin(enc_b), .drv_in(drv),
      .slave_freq_dmd(slave_freq_dmd), .final_demand(final_demand), .torque_demand(torque_demand), .ind(ind));
   sdm_master_model u_sdm_master_model (.pclk(pclk), .run(run), .fd_mode(fd), .reverse(rev),
      .enc_a(enc_a), .enc_b(enc_b));

   // 200 MHz clock
   initial
   begin
      forever #2.5 pclk = ~pclk;
   end

   // hang guard; the whole run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         tally_and_finish;
      end
   end

   // decode the pins independently to know the count the design must reach
   always @(negedge pclk)
   begin
      if (fd && enc_a && !pa)
         exp_cnt += enc_b ? -1 : 1;
      if (!fd && enc_a != pa)
         exp_cnt += (enc_a == enc_b) ? -1 : 1;
      pa = enc_a;
   end

   function automatic int sat(input int v, input int m);
      return (v > m) ? m : ((v < -m) ? -m : v);
   endfunction

   // indicator word, zero_speed first, as the design packs it
   function automatic logic [5:0] exp_ind(input int s, input logic ab);
      int a, lo_e, hi_e;
      a = (s < 0) ? -s : s;
      lo_e = ab ? LO : RF - LO;
      hi_e = ab ? UPV : RF + UPV;
      return {a <= ZT, a >= lo_e && a <= hi_e, a > hi_e, a < lo_e, tr, rs};
   endfunction

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask

   // one APB transfer; an idle edge first keeps drivers from reassigning in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready, read data and error are all taken at the same rising edge
      while (!done)
      begin
         @(posedge pclk);
         done = (pready === 1'b1);
         rd = prdata;
         er = pslverr;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input int d);
      apb(1'b1, a, {16'h0, d[15:0]});
   endtask

   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(n, x, rd);
   endtask

   // one speed sample pulse, then let the results land
   task automatic tick;
      drv.sample_tick <= 1'b1;
      @(posedge pclk);
      drv.sample_tick <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      for (int i = 0; i < 8; i++)
         rdc("reset value", ra[i], {16'h0, rv[i]});
      apb(1'b0, 8'h38, 32'h0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped slverr", 32'h1, {31'h0, er});
      // open loop zero speed on the 1.0 Hz default
      for (int i = 10; i < 12; i++)
      begin
         drv.motor_freq <= 16'(-i);
         tick;
         chk("ol zero", {31'h0, i == 10}, {31'h0, ind.zero_speed});
      end
      // slaving: quadrature, F+D, then F+D while disabled; each run reverses midway
      for (int m = 0; m < 3; m++)
      begin
         r = 64 + ($random(seed) & 511);
         fd <= (m != 0);
         wr(`SDM_RATIO_OFS, r);
         wr(`SDM_CTRL_OFS, (1 << `SDM_CTRL_SLAVE) | ((m < 2) << `SDM_CTRL_ENABLE) | ((m != 0) << `SDM_CTRL_FD));
         repeat (6) @(posedge pclk);
         tick;
         exp_cnt = 0;
         for (int k = 0; k < 2; k++)
         begin
            rev <= (k == 1);
            repeat (4) @(posedge pclk);
            run <= 1'b1;
            repeat (30 + ($random(seed) & 31)) @(posedge pclk);
            run <= 1'b0;
         end
         repeat (8) @(posedge pclk);
         tick;
         e = (m < 2) ? sat((exp_cnt * r) >>> 8, 10000) : 0;
         chk("slave demand", 32'(e), 32'(slave_freq_dmd));
         rdc("slave reg", `SDM_SLAVE_OFS, e);
      end
      // closed loop demand, error and torque with the default gain and limit
      // the last row runs with the hard reference switched off
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed) % 30000;
         h = $random(seed) % 30000;
         f = $random(seed) % 2000;
         if (i == 0)
            f = sat(r + h, 30000) - 7;
         wr(`SDM_CTRL_OFS, (i == 3) ? 32'h15 : 32'h1D);
         wr(`SDM_HARD_REF_OFS, h);
         drv.ramp_out <= 16'(r);
         drv.enc_fb <= 16'(f);
         tick;
         fin = sat(r + ((i == 3) ? 0 : h), 30000);
         chk("final demand", 32'(fin), 32'(final_demand));
         tick;
         e = sat(fin - f, 30000);
         rdc("speed error", `SDM_ERR_OFS, e);
         tick;
         chk("torque", 32'(sat((e * 200) >>> 4, 200)), 32'(torque_demand));
      end
      wr(`SDM_CTRL_OFS, 32'h19);
      tick;
      chk("final disabled", 32'h0, 32'(final_demand));
      // indicators: absolute window rows, then reference window rows
      wr(`SDM_CTRL_OFS, 32'h1D);
      wr(`SDM_ZERO_THR_OFS, ZT);
      wr(`SDM_LOW_THR_OFS, LO);
      wr(`SDM_UP_THR_OFS, UPV);
      wr(`SDM_OVSPD_OFS, OV);
      rdc("lower thr", `SDM_LOW_THR_OFS, LO);
      rdc("upper thr", `SDM_UP_THR_OFS, UPV);
      // trip sets above the threshold, then software clears it; the flag is read an edge after the write
      drv.enc_fb <= 16'(OV + 1);
      tick;
      chk("trip set", 32'h1, {31'h0, ind.overspeed_trip});
      wr(`SDM_STATUS_OFS, 1 << `SDM_ST_TRIP);
      @(posedge pclk);
      chk("trip clear", 32'h0, {31'h0, ind.overspeed_trip});
      drv.pre_ramp_ref <= 16'(-RF);
      for (int i = 0; i < 10; i++)
      begin
         if (i == 6)
            wr(`SDM_CTRL_OFS, 32'h0D);
         drv.enc_fb <= 16'(sp[i]);
         tick;
         chk("indicators", {26'h0, exp_ind(sp[i], i < 6)}, {26'h0, ind});
      end
      drv.enc_fb <= 16'h0000;
      repeat (4) @(posedge pclk);
      chk("no tick hold", {26'h0, exp_ind(801, 1'b0)}, {26'h0, ind});
      // a tick while the clock enable is low must change nothing
      clk_en <= 1'b0;
      tick;
      clk_en <= 1'b1;
      chk("frozen", {26'h0, exp_ind(801, 1'b0)}, {26'h0, ind});
      // sine-cosine feedback chosen by the control bit, resolver absent
      wr(`SDM_CTRL_OFS, 32'h4D);
      drv.sine_cosine_encoder_fitted <= 1'b1;
      drv.sine_cosine_encoder_fb <= 16'(-700);
      tick;
      chk("sine-cosine", {26'h0, exp_ind(-700, 1'b0)}, {26'h0, ind});
      drv.res_fitted <= 1'b1;
      drv.res_fb <= 16'(-600);
      rs = 1'b1;
      tick;
      chk("resolver", {26'h0, exp_ind(-600, 1'b0)}, {26'h0, ind});
      drv.res_fb <= 16'(OV + 1);
      tr = 1'b1;
      tick;
      chk("overspeed", {26'h0, exp_ind(OV + 1, 1'b0)}, {26'h0, ind});
      tally_and_finish;
   end
endmodule
